// >>> verilog/afe_control_register.v
`timescale 1ns/1ps
`include "afe_ctl_regs.vh"
module afe_control_register #(
  parameter [`AFE_CNT_WIDTH-1:0] FRAME_CYCLES = `AFE_FRAME_DEFAULT
) (
  // Clock and reset.
  input wire mclk,
  input wire rst,
  // Configuration pins.
  input wire iface_cfg_a,
  input wire iface_cfg_b,
  input wire master_mode,
  // Serial host port, inputs synchronous to mclk.
  input wire sclk_rise,
  input wire fs_primary,
  input wire fs_secondary_in,
  input wire din,
  // Secondary sync out, active low enable while driven.
  output reg fs_secondary_out_ff,
  output reg fs_secondary_oe_n_ff,
  // Decoded control fields.
  output reg [`AFE_CTL_WIDTH-1:0] afe_control_ff,
  output reg input_select_ff,
  output reg rx_gain_sel_ff,
  output reg [2:0] osr_code_ff,
  output reg osr_reserved_ff,
  output reg [1:0] tx_atten_ff,
  output reg tx_mute_ff,
  output reg [2:0] post_div_ff,
  output reg q_half_ff,
  output reg [1:0] m_sel_ff,
  output reg m_reserved_ff,
  output reg test_bits_set_ff,
  output reg ctrl_mode_ff,
  output reg data16_ff
);
  // ---------------------------------------------------------------
  // Transfer mode decode
  // ---------------------------------------------------------------
  reg ctrl_en_ff;
  reg [`AFE_CNT_WIDTH-1:0] frame_cnt_ff;
  reg [`AFE_CNT_WIDTH-1:0] period_ff;
  reg sec_strobe_ff;
  wire [`AFE_CTL_WIDTH-1:0] pri_word;
  wire pri_done;
  wire [`AFE_CTL_WIDTH-1:0] sec_word;
  wire sec_done;
  wire sec_sync;
  wire hw_ctrl;
  reg [`AFE_CTL_WIDTH-1:0] nxt_ctl;
  wire sec_start;
  wire sec_load;

  // Hardware mode enables control with config b high; software mode
  // needs the primary word LSB set.
  assign hw_ctrl = iface_cfg_b;
  // Secondary sync comes from our generator as master, else from host.
  assign sec_sync = master_mode ? sec_strobe_ff : fs_secondary_in;
  // A secondary sync only arms the receiver while control transfers are
  // enabled, so a host sync in data-only mode leaves the word untouched.
  assign sec_start = sec_sync & ctrl_en_ff;
  // A finished word loads only if control is still enabled at its end.
  assign sec_load = sec_done & ctrl_en_ff;

  // ---------------------------------------------------------------
  // Serial receivers
  // ---------------------------------------------------------------
  // Primary receiver: data words, and the mode bit in software mode.
  afe_ctl_shift #(.WIDTH(`AFE_CTL_WIDTH)) u_pri (
    .mclk(mclk),
    .rst(rst),
    .start(fs_primary),
    .bit_en(sclk_rise),
    .din(din),
    .word_ff(pri_word),
    .done_ff(pri_done)
  );

  // Secondary receiver: the only path into the control word.
  afe_ctl_shift #(.WIDTH(`AFE_CTL_WIDTH)) u_sec (
    .mclk(mclk),
    .rst(rst),
    .start(sec_start),
    .bit_en(sclk_rise),
    .din(din),
    .word_ff(sec_word),
    .done_ff(sec_done)
  );

  // ---------------------------------------------------------------
  // Control transfer enable
  // ---------------------------------------------------------------
  // Control enable follows the configuration; reset always drops back
  // to data-only, and in software mode it stays there until the host asks again.
  always @(posedge mclk) begin
    if (rst) begin
      ctrl_en_ff <= 1'b0;
    end else if (hw_ctrl) begin
      ctrl_en_ff <= 1'b1;
    end else if (iface_cfg_a) begin
      ctrl_en_ff <= 1'b0;
    end else if (pri_done) begin
      ctrl_en_ff <= pri_word[0];
    end
  end

  // ---------------------------------------------------------------
  // Secondary sync generator
  // ---------------------------------------------------------------
  // Frame length is learned from primary spacing; until then the
  // default is used so a secondary sync still lands mid-frame.
  // The learned length trails by one frame, so after a change of frame
  // rate the first secondary sync is placed by the old length.
  always @(posedge mclk) begin
    if (rst) begin
      frame_cnt_ff <= {`AFE_CNT_WIDTH{1'b0}};
      period_ff <= FRAME_CYCLES;
      sec_strobe_ff <= 1'b0;
      fs_secondary_out_ff <= 1'b0;
      fs_secondary_oe_n_ff <= 1'b1;
    end else begin
      sec_strobe_ff <= 1'b0;
      if (fs_primary) begin
        frame_cnt_ff <= {`AFE_CNT_WIDTH{1'b0}};
        if (frame_cnt_ff != {`AFE_CNT_WIDTH{1'b0}}) begin
          period_ff <= frame_cnt_ff + 16'h0001;
        end
      end else begin
        frame_cnt_ff <= frame_cnt_ff + 16'h0001;
        if (master_mode && ctrl_en_ff && frame_cnt_ff == {1'b0, period_ff[15:1]}) begin
          sec_strobe_ff <= 1'b1;
        end
      end
      fs_secondary_out_ff <= sec_strobe_ff;
      fs_secondary_oe_n_ff <= ~(master_mode & ctrl_en_ff);
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  // Bit 0 is stored as zero whatever was shifted in.
  always @* begin
    nxt_ctl = {sec_word[15:1], 1'b0};
  end

  // Only the secondary receiver can load; primary words carry data.
  always @(posedge mclk) begin
    if (rst) begin
      afe_control_ff <= `AFE_CTL_RESET;
    end else if (sec_load) begin
      afe_control_ff <= nxt_ctl;
    end
  end

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  // Decoded fields trail the stored word by one cycle; reserved codes are
  // flagged, not blocked, since the host owns the obligation not to write them.

  // Receive path: input source, gain step and oversampling ratio.
  always @(posedge mclk) begin
    if (rst) begin
      input_select_ff <= 1'b0;
      rx_gain_sel_ff <= 1'b0;
      osr_code_ff <= 3'h0;
      osr_reserved_ff <= 1'b0;
    end else begin
      input_select_ff <= afe_control_ff[`AFE_BIT_INPUT_SEL];
      rx_gain_sel_ff <= afe_control_ff[`AFE_BIT_RX_GAIN];
      osr_code_ff <= afe_control_ff[`AFE_OSR_MSB:`AFE_OSR_LSB];
      osr_reserved_ff <= (afe_control_ff[`AFE_OSR_MSB:`AFE_OSR_LSB] == 3'h2) ||
        (afe_control_ff[`AFE_OSR_MSB:`AFE_OSR_LSB] == 3'h3) ||
        (afe_control_ff[`AFE_OSR_MSB:`AFE_OSR_LSB] == 3'h4);
    end
  end

  // Transmit path: attenuation code and mute, muted out of reset.
  always @(posedge mclk) begin
    if (rst) begin
      tx_atten_ff <= 2'h0;
      tx_mute_ff <= 1'b1;
    end else begin
      tx_atten_ff <= afe_control_ff[`AFE_ATT_MSB:`AFE_ATT_LSB];
      tx_mute_ff <= (afe_control_ff[`AFE_ATT_MSB:`AFE_ATT_LSB] == 2'h0);
    end
  end

  // Clock generator dividers; the reset state gives M of 4 and Q of 6.
  always @(posedge mclk) begin
    if (rst) begin
      post_div_ff <= 3'h1;
      q_half_ff <= 1'b0;
      m_sel_ff <= 2'h1;
      m_reserved_ff <= 1'b0;
    end else begin
      post_div_ff <= afe_control_ff[`AFE_Q_MSB:`AFE_Q_LSB];
      q_half_ff <= afe_control_ff[`AFE_Q_MSB];
      // M code: 00/01 give 3/4, 10/11 give 1/2 in this encoding.
      m_sel_ff <= {afe_control_ff[`AFE_BIT_M_B], afe_control_ff[`AFE_BIT_M_LO]};
      m_reserved_ff <= afe_control_ff[`AFE_BIT_M_B] ^ afe_control_ff[`AFE_BIT_M_A];
    end
  end

  // Mode status: test bits, control enable and data width.
  always @(posedge mclk) begin
    if (rst) begin
      test_bits_set_ff <= 1'b0;
      ctrl_mode_ff <= 1'b0;
      data16_ff <= 1'b0;
    end else begin
      test_bits_set_ff <= |afe_control_ff[`AFE_TEST_MSB:`AFE_TEST_LSB];
      ctrl_mode_ff <= ctrl_en_ff;
      data16_ff <= iface_cfg_a | iface_cfg_b;
    end
  end
endmodule // afe_control_register

// >>> verilog/afe_ctl_regs.vh
`ifndef AFE_CTL_REGS_VH
`define AFE_CTL_REGS_VH
// ---------------------------------------------------------------
// Control word layout
// ---------------------------------------------------------------
`define AFE_CTL_WIDTH 16
`define AFE_CTL_RESET 16'h0300
`define AFE_BIT_INPUT_SEL 1
`define AFE_BIT_RX_GAIN 2
`define AFE_OSR_LSB 3
`define AFE_OSR_MSB 5
`define AFE_ATT_LSB 6
`define AFE_ATT_MSB 7
`define AFE_BIT_M_LO 8
`define AFE_Q_LSB 9
`define AFE_Q_MSB 11
`define AFE_BIT_M_A 12
`define AFE_BIT_M_B 13
`define AFE_TEST_LSB 14
`define AFE_TEST_MSB 15
// ---------------------------------------------------------------
// Interface configuration
// ---------------------------------------------------------------
`define AFE_CNT_WIDTH 16
`define AFE_FRAME_DEFAULT 16'h00A0
`endif

// >>> verilog/afe_ctl_shift.v
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Serial word receiver, MSB first
// ---------------------------------------------------------------
module afe_ctl_shift #(
  parameter WIDTH = 16
) (
  // Clock and reset.
  input wire mclk,
  input wire rst,
  // Serial input.
  input wire start,
  input wire bit_en,
  input wire din,
  // Word output.
  output reg [WIDTH-1:0] word_ff,
  output reg done_ff
);
  reg [WIDTH-1:0] shreg_ff;
  reg [4:0] cnt_ff;
  reg busy_ff;

  // A start restarts the word, so a stray start never mixes two words.
  always @(posedge mclk) begin
    if (rst) begin
      shreg_ff <= {WIDTH{1'b0}};
      cnt_ff <= 5'h00;
      busy_ff <= 1'b0;
      word_ff <= {WIDTH{1'b0}};
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        busy_ff <= 1'b1;
        cnt_ff <= 5'h00;
      end else if (busy_ff && bit_en) begin
        shreg_ff <= {shreg_ff[WIDTH-2:0], din};
        if (cnt_ff == WIDTH - 1) begin
          busy_ff <= 1'b0;
          word_ff <= {shreg_ff[WIDTH-2:0], din};
          done_ff <= 1'b1;
        end
        cnt_ff <= cnt_ff + 5'h01;
      end
    end
  end
endmodule // afe_ctl_shift

// >>> testbench/afe_ctl_properties.sv
`timescale 1ns/1ps
// ---------------------------------------
// Control word checker
// ---------------------------------------
module afe_ctl_props (
  // Clock and reset.
  input wire mclk,
  input wire rst,
  // Serial side.
  input wire fs_primary,
  input wire fs_secondary_in,
  input wire fs_secondary_out_ff,
  input wire fs_secondary_oe_n_ff,
  input wire ctrl_mode_ff,
  // Register side.
  input wire [15:0] afe_control_ff,
  input wire osr_reserved_ff,
  input wire tx_mute_ff,
  input wire [2:0] post_div_ff,
  input wire [1:0] m_sel_ff,
  input wire m_reserved_ff
);
  reg sec_ff;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Marks an accepted secondary start, so that a load can be traced back to one.
  always @(posedge mclk) begin
    if (rst || fs_primary) sec_ff <= 1'h0;
    else if (ctrl_mode_ff && (fs_secondary_in || fs_secondary_out_ff)) sec_ff <= 1'h1;
  end
  a_reset_word: assert property (disable iff (1'h0)
    rst |=> afe_control_ff == 16'h0300 && !ctrl_mode_ff) else $error("reset word wrong");
  a_word_source: assert property ($changed(afe_control_ff) |-> sec_ff)
    else $error("word loaded without secondary sync");
  a_bit0_clear: assert property (afe_control_ff[0] == 1'h0)
    else $error("bit 0 stored");
  a_osr_resv: assert property (osr_reserved_ff ==
    ($past(afe_control_ff[5:3]) inside {3'h2, 3'h3, 3'h4})) else $error("osr flag wrong");
  a_tx_mute: assert property (tx_mute_ff == ($past(afe_control_ff[7:6]) == 2'h0))
    else $error("mute wrong");
  a_q_div: assert property (post_div_ff == $past(afe_control_ff[11:9]))
    else $error("q divider wrong");
  a_m_div: assert property (m_sel_ff == {$past(afe_control_ff[13]), $past(afe_control_ff[8])}
    && m_reserved_ff == ^$past(afe_control_ff[13:12])) else $error("m divider wrong");
  a_sec_drive: assert property (fs_secondary_out_ff |-> !fs_secondary_oe_n_ff && ctrl_mode_ff)
    else $error("secondary sync undriven");
endmodule // afe_ctl_props
bind afe_control_register afe_ctl_props afe_ctl_props_i (.mclk(mclk), .rst(rst),
  .fs_primary(fs_primary), .fs_secondary_in(fs_secondary_in), .ctrl_mode_ff(ctrl_mode_ff),
  .fs_secondary_out_ff(fs_secondary_out_ff), .fs_secondary_oe_n_ff(fs_secondary_oe_n_ff),
  .afe_control_ff(afe_control_ff), .osr_reserved_ff(osr_reserved_ff), .tx_mute_ff(tx_mute_ff),
  .post_div_ff(post_div_ff), .m_sel_ff(m_sel_ff), .m_reserved_ff(m_reserved_ff));

// >>> testbench/afe_ctl_host.sv
`timescale 1ns/1ps
// ---------------------------------------
// Host serial port model
// ---------------------------------------
module afe_ctl_host (
  // Clock from the bench.
  input wire mclk,
  // Serial lines to the device.
  output reg sclk_rise,
  output reg fs_primary,
  output reg fs_secondary_in,
  output reg din
);
  integer i;
  initial {sclk_rise, fs_primary, fs_secondary_in, din} = 4'h0;
  // Sends a word MSB first; gap idle cycles per bit model a slow host.
  // Idle data shows the inverse of the last bit, so a late sample fails.
  task send(input sec, input [15:0] w, input integer gap);
    begin
      @(posedge mclk) #1;
      {fs_secondary_in, fs_primary} = {sec, !sec};
      @(posedge mclk) #1;
      {fs_secondary_in, fs_primary} = 2'h0;
      for (i = 15; i >= 0; i = i - 1) begin
        din = (sec && i > 13) ? 1'h0 : w[i];
        sclk_rise = 1'h1;
        @(posedge mclk) #1;
        if (gap > 0 || i == 0) begin
          {sclk_rise, din} = {1'h0, !din};
          repeat (gap) @(posedge mclk) #1;
        end
      end
    end
  endtask
endmodule // afe_ctl_host

// >>> testbench/afe_control_register_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run = tests_run + 1; if ((g) !== (e)) begin \
  err_total = err_total + 1; $display("ERROR %s exp %0h got %0h", n, e, g); end end
// ---------------------------------------
// Control register bench
// ---------------------------------------
module afe_control_register_tb;
  reg mclk = 1'h0, rst = 1'h1, cfg_a = 1'h1, cfg_b = 1'h0, mst = 1'h0;
  reg [15:0] w, e;
  reg [2:0] k;
  integer err_total = 0, tests_run = 0, j;
  wire sclk, fsp, fss, din, so, oe_n, isel, gain, ores, mute, qh, mres, tbit, ctl, d16;
  wire [15:0] wd;
  wire [2:0] osr, qd;
  wire [1:0] att, ms;
  wire [15:0] fld = {isel, gain, osr, ores, att, mute, qd, qh, ms, mres};
  // The clock runs at 200 MHz.
  always #2.5 mclk = ~mclk;
  afe_ctl_host afe_ctl_host_i (.mclk(mclk), .sclk_rise(sclk), .fs_primary(fsp),
    .fs_secondary_in(fss), .din(din));
  // A 20-cycle default frame; the master run uses the length learned from primary spacing.
  afe_control_register #(.FRAME_CYCLES(16'h0014)) afe_control_register_i (.mclk(mclk),
    .rst(rst), .iface_cfg_a(cfg_a), .iface_cfg_b(cfg_b), .master_mode(mst), .sclk_rise(sclk),
    .fs_primary(fsp), .fs_secondary_in(fss), .din(din), .fs_secondary_out_ff(so),
    .fs_secondary_oe_n_ff(oe_n), .afe_control_ff(wd), .input_select_ff(isel),
    .rx_gain_sel_ff(gain), .osr_code_ff(osr), .osr_reserved_ff(ores), .tx_atten_ff(att),
    .tx_mute_ff(mute), .post_div_ff(qd), .q_half_ff(qh), .m_sel_ff(ms), .m_reserved_ff(mres),
    .test_bits_set_ff(tbit), .ctrl_mode_ff(ctl), .data16_ff(d16));
  task test_done;
    begin
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Sends a word, then waits out the load and the decode.
  task put(input sec, input [15:0] v, input integer gap);
    begin
      afe_ctl_host_i.send(sec, v, gap);
      repeat (2) @(posedge mclk);
      #1;
    end
  endtask
  // Main sequence; each OSR and Q code is walked once and each M code twice, test bits stay clear.
  initial begin
    repeat (10) @(posedge mclk);
    #1 rst = 1'h0;
    @(posedge mclk) #1;
    `CHK("reset", 22'h00C025, {wd, mute, qd, ms})
    `CHK("mode", 3'h3, {ctl, oe_n, d16})
    put(1'h1, 16'h3FFF, 0);
    `CHK("ctrl off", 16'h0300, wd)
    cfg_b = 1'h1;
    put(1'h0, 16'h1234, 1);
    `CHK("primary", 16'h0300, wd)
    for (j = 0; j < 8; j = j + 1) begin
      k = j[2:0];
      w = {2'h0, k[2], k[1], k, k[0], k[1:0], k, k[1], k[0], 1'h1};
      e = {k[0], k[1], k, j > 1 && j < 5, k[1:0], k[1:0] == 2'h0, k, k[2], k[2], k[0],
        k[2] ^ k[1]};
      put(1'h1, w, j % 2);
      `CHK("word", {w & 16'hFFFE, 3'h5}, {wd, ctl, tbit, d16})
      `CHK("fields", e, fld)
    end
    {cfg_a, cfg_b} = 2'h0;
    put(1'h0, 16'h0000, 0);
    `CHK("lsb 0", 2'h0, {ctl, d16})
    put(1'h1, 16'h0080, 0);
    `CHK("lsb 0 load", 16'h3FFE, wd)
    put(1'h0, 16'h0001, 0);
    put(1'h1, 16'h00C0, 0);
    `CHK("lsb 1 load", 17'h100C0, {ctl, wd})
    {mst, cfg_b} = 2'h3;
    fork
      afe_ctl_host_i.send(1'h0, 16'h0000, 0);
      begin
        for (j = 0; j < 300 && so !== 1'h1; j = j + 1) @(posedge mclk) #1;
        `CHK("master sync seen", 1'h1, so)
        if (so !== 1'h1) test_done;
        `CHK("master sync", 1'h0, oe_n)
      end
    join
    test_done;
  end
endmodule // afe_control_register_tb
